// ===== core/hsm_pkg.sv
// Shared constants and state type of the host shared-memory registers
package hsm_pkg;
   localparam logic [3:0] OFS_ADDR_TOP = 4'h3;
   localparam logic [3:0] OFS_DATA = 4'h4;
   localparam logic [3:0] OFS_PROT_LO = 4'h7;
   localparam logic [3:0] OFS_PROT_HI = 4'h8;
   localparam logic [3:0] OFS_SEM = 4'hc;
   localparam int BIT_RD_PROT = 0;
   localparam int BIT_WR_PROT = 1;
   localparam int BIT_LOCK = 2;
   localparam int BIT_IDX_WR = 3;
   localparam int IDX_LSB = 4;
   localparam int BLK_LSB = 16;
   localparam int NUM_BLOCKS = 32;
   localparam logic [31:0] RST_RD_PROT = 32'h00000000;
   localparam logic [31:0] RST_WR_PROT = 32'hffffffff;
   localparam logic [31:0] RST_LOCK = 32'h00000000;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RST_NIB = 4'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;

   typedef struct packed {
      logic [7:0] addr_top;
      logic [7:0] data;
      logic [3:0] idx_lo;
      logic [3:0] idx_hi;
      logic [31:0] rd_prot;
      logic [31:0] wr_prot;
      logic [31:0] lock;
      logic [3:0] host_owned_flags;
      logic [3:0] core_owned_flags;
      logic semaphore_written_flag;
      logic [7:0] rdata;
      logic mem_wr;
      logic [7:0] mem_wdata;
      logic sync_ready;
      logic sync_error;
   } hsm_state_s;
endpackage

// ===== core/hsm_host_regs.sv
// Host-side shared-memory access registers with block protection
//
// Overview of operation
// - Top indirect address byte drives bits 31-24
// - Data register carries indirect byte 7-0
// - Protection tracked per 64 Kbyte block
// - Low register blocks 0-15, high 16-31
// - Reset sets write-protect, clears read, lock
// - Read-protect bit 0 blocks host reads
// - Core override denies despite host flags
// - Write-protect bit 1 inhibits program, erase
// - Lock freezes block flags until reset
// - Bit 3 set updates index only, reads 0
// - Bit 3 clear applies flags to new index
// - Bits 7-4 hold exposed block index
// - High register indexes map to 16-31
// - Host writes low semaphore nibble
// - Core alone changes high semaphore nibble
// - Semaphore clears on reset
// - Host semaphore write flags core, interrupt
// - Restricted write discarded, error or ready sync
`timescale 1ns/10ps
module hsm_host_regs (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [3:0] host_addr,
   input wire logic [7:0] host_wdata,
   output logic [7:0] host_rdata,
   input wire logic [23:0] ind_addr_low,
   output logic [7:0] ind_addr_top,
   output logic mem_wr,
   output logic [7:0] mem_wdata,
   input wire logic mem_rvalid,
   input wire logic [7:0] mem_rdata,
   input wire logic [2:0] restrict_en,
   input wire logic [1:0] restricted_response_select,
   output logic sync_ready,
   output logic sync_error,
   input wire logic [20:0] chk_addr,
   input wire logic core_ovr_rd_deny,
   input wire logic core_ovr_wr_deny,
   output logic host_rd_denied,
   output logic host_wr_denied,
   input wire logic core_sem_we,
   input wire logic [3:0] core_sem_wdata,
   output logic [7:0] host_core_semaphore,
   input wire logic semw_clr,
   input wire logic semaphore_irq_enable,
   output logic semaphore_written_flag,
   output logic core_irq
);

   hsm_pkg::hsm_state_s s_q;
   hsm_pkg::hsm_state_s s_d;
   logic [4:0] sel;
   logic [4:0] chk_blk;
   logic [4:0] acc_blk;
   logic acc_wr_restricted;
   logic [7:0] prot_lo_rd;
   logic [7:0] prot_hi_rd;
   logic [4:0] blk_lo;
   logic [4:0] blk_hi;

   ////////////////////////////////////////////////////////////////////
   // Block lookups

   assign blk_lo = {1'b0, s_q.idx_lo};
   assign blk_hi = {1'b1, s_q.idx_hi};
   // Index field, zero in bit 3, flags of the indexed block
   assign prot_lo_rd = {s_q.idx_lo, 1'b0, s_q.lock[blk_lo],
                        s_q.wr_prot[blk_lo], s_q.rd_prot[blk_lo]};
   assign prot_hi_rd = {s_q.idx_hi, 1'b0, s_q.lock[blk_hi],
                        s_q.wr_prot[blk_hi], s_q.rd_prot[blk_hi]};

   // Block number is the 64K slot of the core address
   assign chk_blk = chk_addr[hsm_pkg::BLK_LSB+:5];
   assign acc_blk = ind_addr_low[hsm_pkg::BLK_LSB+:5];
   assign host_rd_denied = s_q.rd_prot[chk_blk] | core_ovr_rd_deny;
   assign host_wr_denied = s_q.wr_prot[chk_blk] | core_ovr_wr_deny;

   // Indirect data writes land in expansion memory, so write-protect
   // and any outside restriction (range, warm reset) stop them
   assign acc_wr_restricted = s_q.wr_prot[acc_blk] | core_ovr_wr_deny |
                              (|restrict_en);

   ////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      s_d = s_q;
      sel = 5'h00;
      s_d.mem_wr = 1'b0;
      s_d.sync_ready = 1'b0;
      s_d.sync_error = 1'b0;
      if (mem_rvalid) begin
         s_d.data = mem_rdata;
      end
      if (host_rd) begin
         case (host_addr)
            hsm_pkg::OFS_ADDR_TOP: s_d.rdata = s_q.addr_top;
            hsm_pkg::OFS_DATA: s_d.rdata = s_q.data;
            hsm_pkg::OFS_PROT_LO: s_d.rdata = prot_lo_rd;
            hsm_pkg::OFS_PROT_HI: s_d.rdata = prot_hi_rd;
            hsm_pkg::OFS_SEM: s_d.rdata = {s_q.core_owned_flags,
                                           s_q.host_owned_flags};
            default: s_d.rdata = hsm_pkg::RST_BYTE;
         endcase
      end
      if (host_wr) begin
         case (host_addr)
            hsm_pkg::OFS_ADDR_TOP: begin
               s_d.addr_top = host_wdata;
            end
            hsm_pkg::OFS_DATA: begin
               if (acc_wr_restricted) begin
                  // Data is dropped, only the sync kind is reported
                  if (restricted_response_select == hsm_pkg::RESP_ERR) begin
                     s_d.sync_error = 1'b1;
                  end else begin
                     s_d.sync_ready = 1'b1;
                  end
               end else begin
                  s_d.data = host_wdata;
                  s_d.mem_wr = 1'b1;
                  s_d.mem_wdata = host_wdata;
                  s_d.sync_ready = 1'b1;
               end
            end
            hsm_pkg::OFS_PROT_LO,
            hsm_pkg::OFS_PROT_HI: begin
               if (host_addr == hsm_pkg::OFS_PROT_LO) begin
                  s_d.idx_lo = host_wdata[hsm_pkg::IDX_LSB+:4];
                  sel = {1'b0, host_wdata[hsm_pkg::IDX_LSB+:4]};
               end else begin
                  s_d.idx_hi = host_wdata[hsm_pkg::IDX_LSB+:4];
                  sel = {1'b1, host_wdata[hsm_pkg::IDX_LSB+:4]};
               end
               if (!host_wdata[hsm_pkg::BIT_IDX_WR] && !s_q.lock[sel]) begin
                  s_d.rd_prot[sel] = host_wdata[hsm_pkg::BIT_RD_PROT];
                  s_d.wr_prot[sel] = host_wdata[hsm_pkg::BIT_WR_PROT];
                  s_d.lock[sel] = host_wdata[hsm_pkg::BIT_LOCK];
               end
            end
            hsm_pkg::OFS_SEM: begin
               s_d.host_owned_flags = host_wdata[3:0];
            end
            default: begin
            end
         endcase
      end
      if (core_sem_we) begin
         s_d.core_owned_flags = core_sem_wdata;
      end
      // A host write in the clearing cycle keeps the flag set
      if (semw_clr) begin
         s_d.semaphore_written_flag = 1'b0;
      end
      if (host_wr && host_addr == hsm_pkg::OFS_SEM) begin
         s_d.semaphore_written_flag = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q.addr_top <= hsm_pkg::RST_BYTE;
         s_q.data <= hsm_pkg::RST_BYTE;
         s_q.idx_lo <= hsm_pkg::RST_NIB;
         s_q.idx_hi <= hsm_pkg::RST_NIB;
         s_q.rd_prot <= hsm_pkg::RST_RD_PROT;
         s_q.wr_prot <= hsm_pkg::RST_WR_PROT;
         s_q.lock <= hsm_pkg::RST_LOCK;
         s_q.host_owned_flags <= hsm_pkg::RST_NIB;
         s_q.core_owned_flags <= hsm_pkg::RST_NIB;
         s_q.semaphore_written_flag <= 1'b0;
         s_q.rdata <= hsm_pkg::RST_BYTE;
         s_q.mem_wr <= 1'b0;
         s_q.mem_wdata <= hsm_pkg::RST_BYTE;
         s_q.sync_ready <= 1'b0;
         s_q.sync_error <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs

   assign host_rdata = s_q.rdata;
   assign ind_addr_top = s_q.addr_top;
   assign mem_wr = s_q.mem_wr;
   assign mem_wdata = s_q.mem_wdata;
   assign sync_ready = s_q.sync_ready;
   assign sync_error = s_q.sync_error;
   assign host_core_semaphore = {s_q.core_owned_flags, s_q.host_owned_flags};
   assign semaphore_written_flag = s_q.semaphore_written_flag;
   // Level interrupt: up while enabled, until the core clears the flag
   assign core_irq = s_q.semaphore_written_flag & semaphore_irq_enable;

   ////////////////////////////////////////////////////////////////////
   // Checks

   top_byte_a: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      host_wr && host_addr == hsm_pkg::OFS_ADDR_TOP
      |=> ind_addr_top == $past(host_wdata))
      else $error("top address byte not taken");

   idx_only_a: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      host_wr && host_addr == hsm_pkg::OFS_PROT_LO && host_wdata[3]
      |=> s_q.rd_prot == $past(s_q.rd_prot) &&
          s_q.wr_prot == $past(s_q.wr_prot) &&
          s_q.lock == $past(s_q.lock))
      else $error("index write changed flags");

   idx_hi_only_a: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      host_wr && host_addr == hsm_pkg::OFS_PROT_HI && host_wdata[3]
      |=> s_q.rd_prot == $past(s_q.rd_prot) &&
          s_q.wr_prot == $past(s_q.wr_prot) &&
          s_q.lock == $past(s_q.lock))
      else $error("high index write changed flags");

   idx_read_a: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      host_rd && host_addr == hsm_pkg::OFS_PROT_HI
      |=> host_rdata[3] == 1'b0 && host_rdata[7:4] == $past(s_q.idx_hi))
      else $error("protection readback wrong");

   lo_read_a: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      host_rd && host_addr == hsm_pkg::OFS_PROT_LO
      |=> host_rdata[3] == 1'b0 && host_rdata[7:4] == $past(s_q.idx_lo))
      else $error("low protection readback wrong");

   lock_hold_a: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      s_q.lock[blk_lo] |=> s_q.lock[$past(blk_lo)] &&
      s_q.rd_prot[$past(blk_lo)] == $past(s_q.rd_prot[blk_lo]))
      else $error("locked block changed");

   lock_stick_a: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      s_q.lock != 32'h0 |=>
      ($past(s_q.lock) & ~s_q.lock) == 32'h0)
      else $error("lock flag cleared without reset");

   lock_hi_a: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      host_wr && host_addr == hsm_pkg::OFS_PROT_HI &&
      s_q.lock[{1'b1, host_wdata[7:4]}]
      |=> s_q.rd_prot == $past(s_q.rd_prot) &&
          s_q.wr_prot == $past(s_q.wr_prot))
      else $error("locked high block changed");

   flag_apply_a: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      host_wr && host_addr == hsm_pkg::OFS_PROT_HI && !host_wdata[3] &&
      !s_q.lock[{1'b1, host_wdata[7:4]}]
      |=> s_q.wr_prot[{1'b1, $past(host_wdata[7:4])}] ==
          $past(host_wdata[1]))
      else $error("flag write not applied");

   lo_apply_a: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      host_wr && host_addr == hsm_pkg::OFS_PROT_LO && !host_wdata[3] &&
      !s_q.lock[{1'b0, host_wdata[7:4]}]
      |=> s_q.rd_prot[{1'b0, $past(host_wdata[7:4])}] ==
          $past(host_wdata[0]) &&
          s_q.lock[{1'b0, $past(host_wdata[7:4])}] == $past(host_wdata[2]))
      else $error("low flag write not applied");

   hi_map_a: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      host_wr && host_addr == hsm_pkg::OFS_PROT_HI && !host_wdata[3] &&
      !s_q.lock[{1'b1, host_wdata[7:4]}]
      |=> s_q.rd_prot[{1'b1, $past(host_wdata[7:4])}] ==
          $past(host_wdata[0]))
      else $error("high index not mapped to upper blocks");

   rd_deny_a: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      host_rd_denied == (s_q.rd_prot[chk_addr[20:16]] | core_ovr_rd_deny))
      else $error("read denial mismatch");

   ovr_deny_a: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      (core_ovr_rd_deny -> host_rd_denied) && (core_ovr_wr_deny -> host_wr_denied))
      else $error("core override not honoured");

   rst_flags_a: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      $rose(arst_n) |-> s_q.rd_prot == hsm_pkg::RST_RD_PROT &&
      s_q.wr_prot == hsm_pkg::RST_WR_PROT && s_q.lock == hsm_pkg::RST_LOCK)
      else $error("protection flags wrong after reset");

   rst_sem_a: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      $rose(arst_n) |-> host_core_semaphore == hsm_pkg::RST_BYTE)
      else $error("semaphore not cleared by reset");

   data_wr_a: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      host_wr && host_addr == hsm_pkg::OFS_DATA && !acc_wr_restricted
      |=> mem_wr && sync_ready && !sync_error &&
          mem_wdata == $past(host_wdata))
      else $error("allowed data write not forwarded");

   data_fill_a: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      mem_rvalid && !(host_wr && host_addr == hsm_pkg::OFS_DATA)
      |=> s_q.data == $past(mem_rdata))
      else $error("memory read data not captured");

   no_stray_a: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      !(host_wr && host_addr == hsm_pkg::OFS_DATA)
      |=> !mem_wr && !sync_ready && !sync_error)
      else $error("stray data write response");

   bad_write_a: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      host_wr && host_addr == hsm_pkg::OFS_DATA && acc_wr_restricted
      |=> !mem_wr && (sync_error == ($past(restricted_response_select) ==
          hsm_pkg::RESP_ERR)) && (sync_ready != sync_error))
      else $error("restricted write response wrong");

   sync_one_a: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      !(sync_ready && sync_error))
      else $error("both sync kinds at once");

   sem_host_a: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      host_wr && host_addr == hsm_pkg::OFS_SEM && !core_sem_we
      |=> host_core_semaphore[3:0] == $past(host_wdata[3:0]) &&
          host_core_semaphore[7:4] == $past(host_core_semaphore[7:4]))
      else $error("semaphore nibble ownership broken");

   sem_core_a: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      core_sem_we |=> host_core_semaphore[7:4] == $past(core_sem_wdata))
      else $error("core semaphore nibble not taken");

   sem_flag_a: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      host_wr && host_addr == hsm_pkg::OFS_SEM
      |=> semaphore_written_flag ##0
          (core_irq == semaphore_irq_enable))
      else $error("semaphore write not flagged");

   sem_wins_a: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      semw_clr && host_wr && host_addr == hsm_pkg::OFS_SEM
      |=> semaphore_written_flag)
      else $error("clear beat a host semaphore write");

endmodule

// ===== testbench/hsm_mem_model.sv
// Shared memory responder behind the indirect data byte
`timescale 1ns/10ps
module hsm_mem_model (
   input wire logic core_clk,
   input wire logic fetch,
   input wire logic [7:0] fetch_data,
   output logic mem_rvalid,
   output logic [7:0] mem_rdata
);
   // Data only means something with the strobe; else inverted junk
   always_ff @(posedge core_clk) begin
      mem_rvalid <= fetch;
      mem_rdata <= fetch ? fetch_data : ~fetch_data;
   end
endmodule

// ===== testbench/hsm_host_regs_tb.sv
// Self-checking bench for the host shared-memory registers
`timescale 1ns/10ps
module hsm_host_regs_tb;
   logic core_clk, arst_n, host_wr, host_rd, mem_wr, mem_rvalid;
   logic [3:0] host_addr, core_sem_wdata;
   logic [7:0] host_wdata, host_rdata, ind_addr_top, mem_wdata, mem_rdata;
   logic [7:0] host_core_semaphore, fetch_data;
   logic [23:0] ind_addr_low;
   logic [20:0] chk_addr;
   logic [2:0] restrict_en;
   logic [1:0] rsel;
   logic sync_ready, sync_error, ovr_rd, ovr_wr, rd_den, wr_den, fetch;
   logic core_sem_we, semw_clr, irq_en, sem_flag, core_irq;
   int error_cnt = 0;
   int num_checks = 0;
   ////////////////////////////////////////////////////////////////////
   hsm_host_regs dut (.core_clk(core_clk), .arst_n(arst_n),
      .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
      .host_wdata(host_wdata), .host_rdata(host_rdata),
      .ind_addr_low(ind_addr_low), .ind_addr_top(ind_addr_top),
      .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rvalid(mem_rvalid),
      .mem_rdata(mem_rdata), .restrict_en(restrict_en),
      .restricted_response_select(rsel), .sync_ready(sync_ready),
      .sync_error(sync_error), .chk_addr(chk_addr),
      .core_ovr_rd_deny(ovr_rd), .core_ovr_wr_deny(ovr_wr),
      .host_rd_denied(rd_den), .host_wr_denied(wr_den),
      .core_sem_we(core_sem_we), .core_sem_wdata(core_sem_wdata),
      .host_core_semaphore(host_core_semaphore), .semw_clr(semw_clr),
      .semaphore_irq_enable(irq_en), .semaphore_written_flag(sem_flag),
      .core_irq(core_irq));
   hsm_mem_model mem (.core_clk(core_clk), .fetch(fetch),
      .fetch_data(fetch_data), .mem_rvalid(mem_rvalid),
      .mem_rdata(mem_rdata));
   ////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick();
      @(posedge core_clk) #2;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      tick();
      host_wr = 1;
      host_addr = a;
      host_wdata = d;
      tick();
      host_wr = 0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      tick();
      host_rd = 1;
      host_addr = a;
      tick();
      host_rd = 0;
      chk(host_rdata, e);
   endtask
   // Block lookup through the core address check port
   task automatic blk(input logic [4:0] b, input logic er, input logic ew);
      chk_addr = {b, 16'h0123};
      #1;
      chk(rd_den, er);
      chk(wr_den, ew);
   endtask
   // Data byte write, then the sync and forward pulses one cycle on
   task automatic dwr(input logic [7:0] d, input logic ok, input logic er);
      wr(4'h4, d);
      chk(mem_wr, ok);
      chk(sync_error, er);
      chk(sync_ready, !er);
   endtask
   task automatic rst();
      arst_n = 0;
      repeat (4) @(posedge core_clk);
      #2 arst_n = 1;
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Real run is under a hundred cycles; generous margin for a hang
   initial begin
      #100us;
      error_cnt++;
      summarize();
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      {host_wr, host_rd, host_addr, host_wdata, ind_addr_low} = '0;
      {restrict_en, rsel, chk_addr, ovr_rd, ovr_wr, fetch} = '0;
      {core_sem_we, core_sem_wdata, semw_clr, irq_en, fetch_data} = '0;
      rst();
      rd(4'h7, 8'h02);
      rd(4'h8, 8'h02);
      rd(4'hc, 8'h00);
      blk(5'd31, 0, 1);
      wr(4'h3, 8'ha5);
      chk(ind_addr_top, 8'ha5);
      rd(4'h3, 8'ha5);
      wr(4'h5, 8'hff);
      rd(4'h5, 8'h00);
      wr(4'h7, 8'h31);
      rd(4'h7, 8'h31);
      blk(5'd3, 1, 0);
      wr(4'h7, 8'h58);
      rd(4'h7, 8'h52);
      wr(4'h7, 8'h38);
      rd(4'h7, 8'h31);
      wr(4'h8, 8'h27);
      wr(4'h8, 8'h20);
      rd(4'h8, 8'h27);
      blk(5'd18, 1, 1);
      blk(5'd2, 0, 1);
      ovr_wr = 1;
      blk(5'd3, 1, 1);
      ovr_wr = 0;
      ovr_rd = 1;
      blk(5'd2, 1, 1);
      ovr_rd = 0;
      ind_addr_low = 24'h03_0010;
      dwr(8'h5a, 1, 0);
      chk(mem_wdata, 8'h5a);
      rsel = 2'h2;
      restrict_en = 3'h4;
      dwr(8'h11, 0, 1);
      restrict_en = 3'h0;
      ind_addr_low = 24'h05_0010;
      dwr(8'h22, 0, 1);
      rsel = 2'h1;
      dwr(8'h33, 0, 0);
      rd(4'h4, 8'h5a);
      fetch_data = 8'h3c;
      fetch = 1;
      tick();
      fetch = 0;
      rd(4'h4, 8'h3c);
      irq_en = 1;
      wr(4'hc, 8'hff);
      chk(host_core_semaphore, 8'h0f);
      chk({sem_flag, core_irq}, 8'h03);
      core_sem_wdata = 4'h9;
      core_sem_we = 1;
      tick();
      core_sem_we = 0;
      rd(4'hc, 8'h9f);
      semw_clr = 1;
      irq_en = 0;
      tick();
      semw_clr = 0;
      chk(sem_flag, 1'b0);
      wr(4'hc, 8'h05);
      chk({sem_flag, core_irq}, 8'h02);
      // Clear held across the write: the host write must win
      semw_clr = 1;
      wr(4'hc, 8'h06);
      semw_clr = 0;
      chk(sem_flag, 1'b1);
      rst();
      wr(4'h8, 8'h28);
      rd(4'h8, 8'h22);
      rd(4'hc, 8'h00);
      summarize();
   end
endmodule
